// ---- inc/wme_regs.vh ----
// register offsets, field positions and reset values of the write mode block
`ifndef WME_REGS_VH
`define WME_REGS_VH
`define WME_CTRL_INDEX 8'h0b
`define WME_CTRL_RESET 8'h0f
`define WME_CTRL_MASK 8'h3f
`define WME_BIT_OFS_EN 0
`define WME_BIT_BY8 1
`define WME_BIT_EXT_WR 2
`define WME_BIT_LATCH8 3
`define WME_BIT_PIX16 4
`define WME_BIT_GRAN 5
`define WME_GMODE_EXT_BIT 2
`define WME_SHIFT_BY8 3'h3
`define WME_SHIFT_BY16 3'h4
`define WME_BYTES_LATCH4 5'h04
`define WME_BYTES_LATCH8 5'h08
`define WME_XFER_BY8 5'h08
`define WME_XFER_BY16 5'h10
`define WME_XFER_ONE 5'h01
`endif

// ---- hw/wme_write_mode_ext.v ----
// write mode extension control register and address/offset formation
`timescale 1ns/1ps
`include "wme_regs.vh"

module wme_write_mode_ext (
    ref_clk,
    rst_n,
    reg_index,
    reg_wr,
    reg_wdata,
    reg_rdata,
    graphics_mode_register,
    first_bank_offset,
    second_bank_offset,
    cpu_addr,
    mem_addr,
    addr_shift,
    latch_bytes,
    xfer_bytes,
    ext_write_mode_sel,
    wide_latch_en
);
    input wire ref_clk;
    input wire rst_n;
    input wire [7:0] reg_index;
    input wire reg_wr;
    input wire [7:0] reg_wdata;
    output reg [7:0] reg_rdata;
    input wire [7:0] graphics_mode_register;
    input wire [7:0] first_bank_offset;
    input wire [7:0] second_bank_offset;
    input wire [22:0] cpu_addr;
    output reg [22:0] mem_addr;
    output reg [2:0] addr_shift;
    output reg [4:0] latch_bytes;
    output reg [4:0] xfer_bytes;
    output reg ext_write_mode_sel;
    output reg wide_latch_en;

    ////////////////////////////////////////////////////////////////////
    // decode helpers
    ////////////////////////////////////////////////////////////////////

    // one index decode shared by the write path and the read path
    function is_ctrl_index;
        input [7:0] idx;
        begin
            is_ctrl_index = (idx == `WME_CTRL_INDEX);
        end
    endfunction

    // host address shift for the given mode bits
    function [2:0] shift_of;
        input pix_on;
        input by8_on;
        begin
            if (pix_on) begin
                // by-8 bit is a don't care here
                shift_of = `WME_SHIFT_BY16;
            end else if (by8_on) begin
                shift_of = `WME_SHIFT_BY8;
            end else begin
                shift_of = 3'h0;
            end
        end
    endfunction

    // bytes that one host byte may write in the given mode
    function [4:0] xfer_of;
        input pix_on;
        input by8_on;
        input ext_on;
        begin
            if (pix_on) begin
                xfer_of = `WME_XFER_BY16;
            end else if (by8_on && ext_on) begin
                xfer_of = `WME_XFER_BY8;
            end else begin
                xfer_of = `WME_XFER_ONE;
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // control register
    ////////////////////////////////////////////////////////////////////

    reg [7:0] ctrl_q;
    reg [7:0] ctrl_d;
    wire ctrl_hit;
    wire ofs_en;
    wire by8;
    wire ext_wr;
    wire latch8;
    wire pix16;
    wire gran;

    assign ctrl_hit = is_ctrl_index(reg_index);
    assign ofs_en = ctrl_q[`WME_BIT_OFS_EN];
    assign by8 = ctrl_q[`WME_BIT_BY8];
    assign ext_wr = ctrl_q[`WME_BIT_EXT_WR];
    assign latch8 = ctrl_q[`WME_BIT_LATCH8];
    // pix16 only acts with extended writes on
    assign pix16 = ctrl_q[`WME_BIT_PIX16] & ext_wr;
    assign gran = ctrl_q[`WME_BIT_GRAN];

    always @* begin
        ctrl_d = ctrl_q;
        if (reg_wr && ctrl_hit) begin
            // reserved bits 7:6 are not stored and read zero
            ctrl_d = reg_wdata & `WME_CTRL_MASK;
        end
    end

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            ctrl_q <= `WME_CTRL_RESET;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // reads have no side effect, so read data is purely combinational
    always @* begin
        if (is_ctrl_index(reg_index)) begin
            reg_rdata = ctrl_q;
        end else begin
            reg_rdata = 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // bank offset selection
    ////////////////////////////////////////////////////////////////////

    reg [7:0] ofs_d;

    always @* begin
        // with offset enable held clear, bit 15 never matters
        if (ofs_en && cpu_addr[15]) begin
            ofs_d = second_bank_offset;
        end else begin
            ofs_d = first_bank_offset;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // address shifter
    ////////////////////////////////////////////////////////////////////

    wire [2:0] shift_d;
    wire [22:0] shifted_d;

    assign shift_d = shift_of(pix16, by8);

    // one mux per address bit; zeros fill from below and bits pushed
    // past the top are lost, so software must keep the window in range
    genvar gi;
    generate
        for (gi = 0; gi < 23; gi = gi + 1) begin : g_shift
            wire bit_by8;
            wire bit_by16;
            if (gi >= 3) begin : g_lo3
                assign bit_by8 = cpu_addr[gi - 3];
            end else begin : g_z3
                assign bit_by8 = 1'b0;
            end
            if (gi >= 4) begin : g_lo4
                assign bit_by16 = cpu_addr[gi - 4];
            end else begin : g_z4
                assign bit_by16 = 1'b0;
            end
            assign shifted_d[gi] =
                (shift_d == `WME_SHIFT_BY16) ? bit_by16 :
                (shift_d == `WME_SHIFT_BY8) ? bit_by8 :
                cpu_addr[gi];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // offset addition
    ////////////////////////////////////////////////////////////////////

    wire [22:0] ofs_add_d;
    wire [22:0] base_d;

    // coarse granularity drops offset bit 7 and lands two bits higher
    assign ofs_add_d = gran ? {2'h0, ofs_d[6:0], 14'h0000} :
        {3'h0, ofs_d, 12'h000};

    // carry out of bit 22 is dropped: the window wraps, by intent
    assign base_d = shifted_d + ofs_add_d;

    ////////////////////////////////////////////////////////////////////
    // registered outputs
    ////////////////////////////////////////////////////////////////////

    // all outputs but reg_rdata follow the control register one edge later, which
    // keeps the read path free of the adder's delay
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            mem_addr <= 23'h000000;
            addr_shift <= 3'h0;
            latch_bytes <= `WME_BYTES_LATCH4;
            xfer_bytes <= `WME_XFER_ONE;
            ext_write_mode_sel <= 1'b0;
            wide_latch_en <= 1'b0;
        end else begin
            mem_addr <= base_d;
            addr_shift <= shift_d;
            wide_latch_en <= latch8;
            if (latch8) begin
                latch_bytes <= `WME_BYTES_LATCH8;
            end else begin
                latch_bytes <= `WME_BYTES_LATCH4;
            end
            ext_write_mode_sel <= ext_wr &
                graphics_mode_register[`WME_GMODE_EXT_BIT];
            xfer_bytes <= xfer_of(pix16, by8, ext_wr);
        end
    end

endmodule // wme_write_mode_ext

// ---- tb/wme_cpu_model.sv ----
// host bus master model presenting CPU addresses
`timescale 1ns/1ps
module wme_cpu_model (input wire ref_clk, input wire [22:0] tgt,
    output reg [22:0] cpu_addr = 23'h0);
    // address moves just after the edge, as a real master would
    always @(posedge ref_clk) cpu_addr <= tgt;
endmodule // wme_cpu_model

// ---- tb/wme_checker_properties.sv ----
// port assertions for the write mode extension block
`timescale 1ns/1ps
module wme_checker (input wire ref_clk, input wire rst_n,
    input wire reg_wr, input wire [7:0] reg_index,
    input wire [7:0] reg_rdata, input wire [2:0] addr_shift,
    input wire [4:0] latch_bytes, input wire [4:0] xfer_bytes,
    input wire ext_write_mode_sel);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // control value reads back whenever its index is selected; rd also requires no write in progress
    wire rd = reg_index == 8'h0b && !reg_wr;
    property p_a; xfer_bytes == 5'h08 |-> addr_shift == 3'h3; endproperty
    a_a: assert property (p_a) else $error("x8");
    property p_b; xfer_bytes == 5'h10 |-> addr_shift == 3'h4; endproperty
    a_b: assert property (p_b) else $error("x16");
    property p_c; addr_shift == 3'h0 |-> xfer_bytes == 5'h01; endproperty
    a_c: assert property (p_c) else $error("x1");
    property p_d; rd |=> latch_bytes[3] == $past(reg_rdata[3]); endproperty
    a_d: assert property (p_d) else $error("latch");
    property p_e; rd && !reg_rdata[2] |=> !ext_write_mode_sel; endproperty
    a_e: assert property (p_e) else $error("ext");
    property p_f; rd && reg_rdata[4] && reg_rdata[2] |=> addr_shift == 3'h4;
    endproperty
    a_f: assert property (p_f) else $error("s16");
    property p_g; rd && reg_rdata[4:1] == 4'h7 |=> addr_shift == 3'h3;
    endproperty
    a_g: assert property (p_g) else $error("s8");
    property p_h; reg_index != 8'h0b |-> reg_rdata == 8'h00; endproperty
    a_h: assert property (p_h) else $error("idx");
endmodule // wme_checker

// ---- tb/tb.sv ----
// self-checking bench for the write mode extension block
`timescale 1ns/1ps
module tb;
    reg ref_clk = 0, rst_n = 0, reg_wr = 0;
    reg [7:0] reg_index = 8'h0b, reg_wdata = 8'h00, gm = 8'h04;
    reg [22:0] tgt = 23'h0;
    wire [22:0] ca, ma;
    wire [7:0] rdat;
    wire [2:0] sh;
    wire [4:0] lb, xb;
    wire es, wl;
    integer num_errors = 0, total_checks = 0;
    initial forever #12.5 ref_clk = ~ref_clk;
    wme_cpu_model i_cpu (.ref_clk, .tgt, .cpu_addr(ca));
    wme_write_mode_ext i_dut (.ref_clk, .rst_n, .reg_index, .reg_wr,
        .reg_wdata, .reg_rdata(rdat), .graphics_mode_register(gm),
        .first_bank_offset(8'h01), .second_bank_offset(8'h02),
        .cpu_addr(ca), .mem_addr(ma), .addr_shift(sh), .latch_bytes(lb),
        .xfer_bytes(xb), .ext_write_mode_sel(es), .wide_latch_en(wl));
    task chk(input [22:0] g, e);
        total_checks = total_checks + 1;
        if (g !== e) begin
            num_errors = num_errors + 1;
            $display("CHECK FAILED %0t got %h want %h", $time, g, e);
        end
    endtask
    // write, then look once the derived outputs have followed
    task st(input [7:0] a, d, input [20:0] e);
        @(negedge ref_clk) {reg_index, reg_wdata, reg_wr} = {a, d, 1'b1};
        @(negedge ref_clk) {reg_index, reg_wr} = {8'h0b, 1'b0};
        @(negedge ref_clk) chk({2'h0, rdat, sh, xb, lb}, {2'h0, e});
        $display("step %h done", d);
    endtask
    task conclude;
        $display("%0d checks, %0d errors", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        #1000000 num_errors = num_errors + 1;
        conclude;
    end
    initial begin
        repeat (12) @(negedge ref_clk);
        rst_n = 1;
        st(8'h0d, 8'hff, {8'h0f, 3'h3, 5'h08, 5'h08});
        st(8'h0b, 8'hff, {8'h3f, 3'h4, 5'h10, 5'h08});
        st(8'h0b, 8'h14, {8'h14, 3'h4, 5'h10, 5'h04});
        st(8'h0b, 8'h00, {8'h00, 3'h0, 5'h01, 5'h04});
        st(8'h0b, 8'h0e, {8'h0e, 3'h3, 5'h08, 5'h08});
        tgt = 23'h008001;
        repeat (2) @(negedge ref_clk);
        chk(ma, 23'h041008);
        st(8'h0b, 8'h0f, {8'h0f, 3'h3, 5'h08, 5'h08});
        chk(ma, 23'h042008);
        chk({21'h0, es, wl}, 23'h000003);
        gm = 8'h00;
        repeat (2) @(negedge ref_clk);
        chk({21'h0, es, wl}, 23'h000001);
        st(8'h0b, 8'h2f, {8'h2f, 3'h3, 5'h08, 5'h08});
        chk(ma, 23'h048008);
        conclude;
    end
endmodule // tb
bind wme_write_mode_ext wme_checker i_chk (.ref_clk, .rst_n, .reg_wr,
    .reg_index, .reg_rdata, .addr_shift, .latch_bytes, .xfer_bytes,
    .ext_write_mode_sel);
